/* dssp_pkg.sv */
// Constants and carrier types for the dual-slope phase sequencer
package dssp_pkg;

  // ==========================================================
  // Timing counts
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam int PRESCALE = 4;
  localparam logic [11:0] INT_COUNTS = 12'h03E8;
  localparam logic [11:0] DE_MAX_COUNTS = 12'h07D0;
  localparam logic [11:0] CYCLE_COUNTS = 12'h0FA0;
  localparam logic [11:0] INT_LAST = INT_COUNTS - 12'h0001;
  localparam logic [11:0] DE_LAST = INT_COUNTS + DE_MAX_COUNTS - 12'h0001;
  localparam logic [11:0] CYCLE_LAST = CYCLE_COUNTS - 12'h0001;
  localparam logic [13:0] CYCLE_CLKS = 14'h3E80;
  localparam logic [9:0] BP_DIV = 10'h0320;
  localparam logic [8:0] BP_HALF_LAST = 9'((BP_DIV >> 1) - 10'h0001);

  // ==========================================================
  // Reset values and decade limit
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [3:0] DIGIT_RST = 4'h0;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_AZ = 2'b00,
    PH_INT = 2'b01,
    PH_DE = 2'b10
  } dssp_phase_t;

  typedef struct packed {
    logic input_short;
    logic az_loop;
    logic ref_charge;
    logic input_connect;
    logic low_to_common;
    logic ref_to_high;
    logic ref_negative;
  } dssp_switch_t;

  // Switches held in reset already show auto-zero, the phase the sequencer resets into
  localparam dssp_switch_t SW_RST = '{input_short: 1'b1, az_loop: 1'b1, ref_charge: 1'b1, default: 1'b0};

  typedef struct packed {
    logic minus;
    logic [1:0] thousands;
    logic [6:0] hundreds;
    logic [6:0] tens;
    logic [6:0] units;
  } dssp_seg_t;

endpackage

/* dssp_bcd_digit.sv */
// One decade of the decimal conversion counter
module dssp_bcd_digit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [3:0] val_o,
  output logic carry_o
);
  import dssp_pkg::*;

  logic [3:0] val_q;
  logic [3:0] val_d;

  // ==========================================================
  // Decade count
  always_comb begin
    val_d = val_q;
    carry_o = inc_i && (val_q == DIGIT_MAX);
    if (clr_i) begin
      val_d = DIGIT_RST;
    end else if (inc_i) begin
      val_d = (val_q == DIGIT_MAX) ? DIGIT_RST : val_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_q <= 4'h0;
    end else begin
      val_q <= val_d;
    end
  end

  assign val_o = val_q;
endmodule

/* dssp_top.sv */
// Phase sequencer, decimal counter and LCD drive of a dual-slope converter
// Overview of operation
// - Count clock is the oscillator divided by four.
// - Signal integrate always lasts 1000 counts.
// - Every measurement cycle lasts 4000 counts, 16,000 oscillator periods.
// - Phases repeat in order: auto-zero, signal integrate, de-integrate.
// - Auto-zero shorts inputs to common, charges reference, closes offset loop.
// - Integrate opens offset loop, removes short, connects inputs to pins.
// - Comparator sampled at integrate end sets sign and reference polarity.
// - De-integrate ties low input to common, reference onto high input.
// - De-integrate counts until zero crossing; count is the reading.
// - Lamp test forces every segment on, minus sign included, showing -1888.
// - Lamp test holds segments at a constant level, no square wave.
// - De-integrate lasts 1 to 2000 counts; auto-zero takes the rest.
// - Backplane is oscillator over 800; on segments antiphase, off in phase.
module dssp_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic comparator_i,
  input wire logic lamp_test_i,
  output dssp_pkg::dssp_switch_t switch_o,
  output logic reference_integrate_phase_o,
  output dssp_pkg::dssp_seg_t seg_o,
  output logic lcd_backplane_drive_o,
  output logic negative_o,
  output logic overrange_o
);
  import dssp_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic comp_m_q, comp_s_q, lamp_m_q, lamp_s_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comp_m_q <= 1'b0;
      comp_s_q <= 1'b0;
      lamp_m_q <= 1'b0;
      lamp_s_q <= 1'b0;
    end else begin
      comp_m_q <= comparator_i;
      comp_s_q <= comp_m_q;
      lamp_m_q <= lamp_test_i;
      lamp_s_q <= lamp_m_q;
    end
  end

  // ==========================================================
  // Sequencer
  logic [1:0] pre_q, pre_d;
  logic tick, crossing, de_end, ovr_hit, bcd_clr, bcd_inc;
  dssp_phase_t phase_q, phase_d;
  logic [11:0] cnt_q, cnt_d;
  logic pol_q, pol_d;
  always_comb begin
    pre_d = pre_q + 2'h1;
    tick = (pre_q == PRE_LAST);
    phase_d = phase_q;
    cnt_d = cnt_q;
    pol_d = pol_q;
    de_end = 1'b0;
    ovr_hit = 1'b0;
    bcd_clr = 1'b0;
    bcd_inc = 1'b0;
    crossing = (comp_s_q != pol_q);
    if (tick) begin
      cnt_d = (cnt_q == CYCLE_LAST) ? CNT_RST : cnt_q + 12'h001;
      case (phase_q)
        PH_AZ: begin
          if (cnt_q == CYCLE_LAST) begin
            phase_d = PH_INT;
          end
        end
        PH_INT: begin
          if (cnt_q == INT_LAST) begin
            phase_d = PH_DE;
            pol_d = comp_s_q;
            bcd_clr = 1'b1;
          end
        end
        PH_DE: begin
          if (crossing) begin
            phase_d = PH_AZ;
            de_end = 1'b1;
          end else if (cnt_q == DE_LAST) begin
            phase_d = PH_AZ;
            de_end = 1'b1;
            ovr_hit = 1'b1;
          end else begin
            bcd_inc = 1'b1;
          end
        end
        default: begin
          phase_d = PH_AZ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= 2'h0;
      phase_q <= PH_AZ;
      cnt_q <= CNT_RST;
      pol_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      pol_q <= pol_d;
    end
  end

  // ==========================================================
  // Analog switch controls
  dssp_switch_t sw_q, sw_d;
  always_comb begin
    sw_d = '0;
    case (phase_d)
      PH_AZ: begin
        sw_d.input_short = 1'b1;
        sw_d.az_loop = 1'b1;
        sw_d.ref_charge = 1'b1;
      end
      PH_INT: begin
        sw_d.input_connect = 1'b1;
      end
      PH_DE: begin
        sw_d.low_to_common = 1'b1;
        sw_d.ref_to_high = 1'b1;
        sw_d.ref_negative = pol_d;
      end
      default: begin
        sw_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_q <= SW_RST;
    end else begin
      sw_q <= sw_d;
    end
  end

  assign switch_o = sw_q;
  assign reference_integrate_phase_o = sw_q.ref_to_high;

  // ==========================================================
  // Decimal counter
  logic [3:0] digit [3];
  logic [3:0] carry;
  logic thou_q, thou_d;
  assign carry[0] = bcd_inc;
  for (genvar i = 0; i < 3; i++) begin : g_digit
    dssp_bcd_digit u_digit (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(bcd_clr),
      .inc_i(carry[i]),
      .val_o(digit[i]),
      .carry_o(carry[i + 1])
    );
  end

  always_comb begin
    thou_d = thou_q;
    if (bcd_clr) begin
      thou_d = 1'b0;
    end else if (carry[3]) begin
      thou_d = 1'b1;
    end
  end

  // ==========================================================
  // Display latch and LCD drive
  logic [11:0] shown_q, shown_d;
  logic shown_thou_q, shown_thou_d, neg_q, neg_d, ovr_q, ovr_d, bp_q, bp_d;
  logic [8:0] bp_cnt_q, bp_cnt_d;
  dssp_seg_t on_w, seg_q, seg_d;
  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction

  always_comb begin
    shown_d = shown_q;
    shown_thou_d = shown_thou_q;
    neg_d = neg_q;
    ovr_d = ovr_q;
    if (de_end) begin
      shown_d = {digit[2], digit[1], digit[0]};
      shown_thou_d = thou_q;
      neg_d = pol_q;
      ovr_d = ovr_hit;
    end
    bp_cnt_d = (bp_cnt_q == BP_HALF_LAST) ? 9'h000 : bp_cnt_q + 9'h001;
    bp_d = (bp_cnt_q == BP_HALF_LAST) ? !bp_q : bp_q;
    on_w.minus = neg_q;
    on_w.thousands = {2{shown_thou_q || ovr_q}};
    on_w.hundreds = ovr_q ? 7'h00 : seg7(shown_q[11:8]);
    on_w.tens = ovr_q ? 7'h00 : seg7(shown_q[7:4]);
    on_w.units = ovr_q ? 7'h00 : seg7(shown_q[3:0]);
    seg_d = lamp_s_q ? '1 : ({$bits(dssp_seg_t){bp_d}} ^ on_w);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thou_q <= 1'b0;
      shown_q <= 12'h000;
      shown_thou_q <= 1'b0;
      neg_q <= 1'b0;
      ovr_q <= 1'b0;
      bp_cnt_q <= 9'h000;
      bp_q <= 1'b0;
      seg_q <= '0;
    end else begin
      thou_q <= thou_d;
      shown_q <= shown_d;
      shown_thou_q <= shown_thou_d;
      neg_q <= neg_d;
      ovr_q <= ovr_d;
      bp_cnt_q <= bp_cnt_d;
      bp_q <= bp_d;
      seg_q <= seg_d;
    end
  end

  assign seg_o = seg_q;
  assign lcd_backplane_drive_o = bp_q;
  assign negative_o = neg_q;
  assign overrange_o = ovr_q;

  // ==========================================================
  // Assertions
  logic [13:0] clk_cnt_q;
  logic seen_q, enter_int;
  assign enter_int = tick && (phase_q == PH_AZ) && (cnt_q == CYCLE_LAST);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_cnt_q <= 14'h0000;
      seen_q <= 1'b0;
    end else begin
      clk_cnt_q <= enter_int ? 14'h0000 : clk_cnt_q + 14'h0001;
      seen_q <= seen_q || enter_int;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence tick_gap_s;
    !tick [*3] ##1 tick;
  endsequence

  prescale_tick_a: assert property (tick |=> tick_gap_s) else $error("count tick not every fourth clock");
  int_length_a: assert property ((phase_q == PH_INT) && (phase_d == PH_DE) |-> tick && (cnt_q == INT_LAST))
    else $error("integrate did not last 1000 counts");
  cycle_length_a: assert property (enter_int && seen_q |-> clk_cnt_q == CYCLE_CLKS - 14'h0001)
    else $error("cycle not 16000 clocks");
  phase_order_a: assert property ((phase_d != phase_q) |-> ((phase_q == PH_AZ) && (phase_d == PH_INT))
    || ((phase_q == PH_INT) && (phase_d == PH_DE)) || ((phase_q == PH_DE) && (phase_d == PH_AZ)))
    else $error("phase order broken");
  az_switches_a: assert property ((phase_q == PH_AZ) |-> sw_q.input_short && sw_q.az_loop && sw_q.ref_charge
    && !sw_q.input_connect && !sw_q.ref_to_high) else $error("auto-zero switches wrong");
  int_switches_a: assert property ((phase_q == PH_INT) |-> sw_q.input_connect && !sw_q.az_loop
    && !sw_q.input_short) else $error("integrate switches wrong");
  polarity_latch_a: assert property ((phase_q == PH_INT) && (phase_d == PH_DE) |=> pol_q == $past(comp_s_q)
    ##1 sw_q.ref_negative == pol_q) else $error("polarity not latched");
  de_switches_a: assert property ((phase_q == PH_DE) |-> sw_q.low_to_common && sw_q.ref_to_high
    && (sw_q.ref_negative == pol_q) && !sw_q.input_connect) else $error("de-integrate switches wrong");
  de_bound_a: assert property ((phase_q == PH_DE) |-> (cnt_q >= INT_COUNTS) && (cnt_q <= DE_LAST))
    else $error("de-integrate over 2000 counts");
  crossing_end_a: assert property (tick && (phase_q == PH_DE) && crossing |=> (phase_q == PH_AZ)
    ##1 !ovr_q) else $error("crossing did not end de-integrate");
  overrange_a: assert property (ovr_hit |=> (phase_q == PH_AZ) ##1 ovr_q) else $error("overrange not shown");
  lamp_level_a: assert property (lamp_s_q |=> (seg_q == '1)) else $error("lamp test not all on");
  backplane_a: assert property (rst_n_i && !lamp_s_q && !$changed(bp_q)
    |=> (seg_q == ({$bits(dssp_seg_t){bp_q}} ^ $past(on_w))) or lamp_s_q) else $error("segment phase wrong");
  display_hold_a: assert property ($changed(shown_q) || $changed(neg_q) |-> $past(de_end))
    else $error("display changed outside de-integrate end");
endmodule

/* dssp_partner.sv */
// Behavioural integrator and comparator facing the sequencer switches
module dssp_partner (
  input wire logic clk_i,
  input wire dssp_pkg::dssp_switch_t switch_i,
  input wire logic [11:0] vin_i,
  input wire logic neg_i,
  output logic comparator_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dssp_pkg::*;
  int clks_q = 0;

  // ==========================================================
  // Integrator ramp
  // Runs back toward zero for four clocks per count of input
  always @(posedge clk_i) begin
    if (!switch_i.ref_to_high) begin
      clks_q <= 0;
    end else begin
      clks_q <= clks_q + 1;
    end
  end

  // Comparator shows the input sign until the ramp crosses zero
  always_comb begin
    if (switch_i.input_connect || (switch_i.ref_to_high && clks_q < 4 * int'(vin_i))) begin
      comparator_o = neg_i;
    end else begin
      comparator_o = ~neg_i;
    end
  end
endmodule

/* testbench.sv */
// Self-checking testbench of the dual-slope phase sequencer
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dssp_pkg::*;
  logic clk_i, rst_n_i, comparator_i, lamp_test_i, neg;
  logic reference_integrate_phase_o, lcd_backplane_drive_o, negative_o, overrange_o;
  dssp_switch_t switch_o;
  dssp_seg_t seg_o;
  logic [11:0] vin;
  int error_cnt, tests_run, cyc, last_t0, last_disp;

  dssp_top dssp_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .comparator_i(comparator_i),
    .lamp_test_i(lamp_test_i), .switch_o(switch_o), .reference_integrate_phase_o(reference_integrate_phase_o),
    .seg_o(seg_o), .lcd_backplane_drive_o(lcd_backplane_drive_o), .negative_o(negative_o),
    .overrange_o(overrange_o));
  dssp_partner dssp_partner_i (.clk_i(clk_i), .switch_i(switch_o), .vin_i(vin), .neg_i(neg),
    .comparator_o(comparator_i));

  // ==========================================================
  // Helpers
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  function automatic int digit_of(logic [6:0] p);
    logic [6:0] tbl [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    for (int i = 0; i < 10; i++) begin
      if (tbl[i] === p) return i;
    end
    // An unknown or broken pattern must never read as a valid digit
    return 10000;
  endfunction

  // Reading shown on the glass, segment levels taken relative to the backplane
  function automatic int shown();
    dssp_seg_t on;
    on = seg_o ^ {24{lcd_backplane_drive_o}};
    return (on.thousands === 2'b11 ? 1000 : 0) + 100 * digit_of(on.hundreds) + 10 * digit_of(on.tens)
      + digit_of(on.units);
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_bit(int idx, logic v);
    int n;
    n = 0;
    while (switch_o[idx] !== v && n < 20000) begin
      tick(1);
      n++;
    end
    `CHK("phase change", 1'b1, switch_o[idx] === v)
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // One measurement cycle with a given input in counts
  task automatic convert(logic [11:0] v, logic n);
    int t0, d;
    logic ovr;
    dssp_seg_t on;
    ovr = v >= DE_MAX_COUNTS;
    @(posedge clk_i);
    vin <= v;
    neg <= n;
    wait_bit(3, 1'b1);
    if (last_t0 > 0) `CHK("cycle length", int'(CYCLE_CLKS), cyc - last_t0)
    if (last_t0 > 0) `CHK("display held", last_disp, shown())
    last_t0 = cyc;
    t0 = cyc;
    `CHK("integrate switches", 7'h08, switch_o)
    wait_bit(3, 1'b0);
    `CHK("integrate length", int'(INT_COUNTS) * PRESCALE, cyc - t0)
    `CHK("deintegrate switches", {6'h03, n}, switch_o)
    `CHK("deintegrate flag", 1'b1, reference_integrate_phase_o)
    t0 = cyc;
    wait_bit(1, 1'b0);
    d = cyc - t0;
    `CHK("autozero switches", 7'h70, switch_o)
    if (ovr) `CHK("overrange length", int'(DE_MAX_COUNTS) * PRESCALE, d)
    else `CHK("deintegrate length", 1'b1, d >= 4 * int'(v) - 8 && d <= 4 * int'(v) + 16)
    tick(3);
    on = seg_o ^ {24{lcd_backplane_drive_o}};
    `CHK("sign", n, negative_o)
    `CHK("sign segment", n, on.minus)
    `CHK("overrange", ovr, overrange_o)
    last_disp = shown();
    if (ovr) `CHK("overrange digits", {2'b11, 21'h00_0000}, on[22:0])
    else `CHK("reading", 1'b1, last_disp >= int'(v) - 2 && last_disp <= int'(v) + 2)
  endtask

  // ==========================================================
  // Backplane half period
  initial begin
    int tb;
    logic bp;
    tb = -1;
    bp = 1'b0;
    forever begin
      tick(1);
      if (lcd_backplane_drive_o !== bp) begin
        if (tb >= 0) `CHK("backplane half period", int'(BP_DIV) / 2, cyc - tb)
        tb = cyc;
      end
      bp = lcd_backplane_drive_o;
    end
  end

  initial begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    end_sim;
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    lamp_test_i = 1'b0;
    vin = 12'h0000;
    neg = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    last_t0 = 0;
    last_disp = 0;
    void'($urandom(32'hee9c_4128));
    tick(20);
    `CHK("reset backplane", 1'b0, lcd_backplane_drive_o)
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(2);
    `CHK("first autozero", 7'h70, switch_o)
    convert(12'h05dc, 1'b0);
    convert(12'(100 + $urandom_range(1899)), 1'b1);
    convert(12'h0834, 1'b0);
    convert(12'(100 + $urandom_range(1899)), 1'($urandom_range(1)));
    @(posedge clk_i);
    lamp_test_i <= 1'b1;
    tick(4);
    `CHK("lamp test", 24'hff_ffff, seg_o)
    tick(500);
    `CHK("lamp test steady", 24'hff_ffff, seg_o)
    @(posedge clk_i);
    lamp_test_i <= 1'b0;
    tick(4);
    `CHK("display after lamp", last_disp, shown())
    end_sim;
  end
endmodule
